/* hdl/sas_ctrl.sv */
// Overview of operation
// - Select high releases the serial output three clock cycles later, without debounce.
// - After select-high debounce, the shift clock is ignored.
// - Select low resets the device only after the debounce interval.
// - Select aborts transfers or conversions; old result is kept.
// - Address 1110 selects power-down, active at fourth falling edge.
// - Powered down: no conversions, previous result retained.
// - Serial logic stays active in power-down; host finishes the cycle.
// - Device starts in power-down after reset.
// - A non-1110 address leaves power-down; conversion follows that cycle.
// - Sampling while idle and not powered down, held at last falling edge.
// - Codes 0000 to 1010 select external channels 0 to 10.
// - Codes 1011, 1100, 1101 select midpoint, lower and upper reference.
// - Twelve bit decisions after hold, MSB first.
// - Trial bit kept when comparator below threshold, else cleared.
// - Result saturates at full scale and zero by comparator decisions.
// - Last pulse is edge 8, 12 or 16 per data length.
// - End-of-conversion rises once result is latched.
`timescale 1ns/10ps
`default_nettype none
module sas_ctrl (
   // System
   input  wire logic                      clk,
   input  wire logic                      rst_n,
   // Serial link, shift clock domain; select and output enable in the system domain
   input  wire logic                      ioClk,
   input  wire logic                      selectN,
   input  wire logic                      dataIn,
   output logic                           dataOut,
   output logic                           dataOutEn,
   // Analog front end
   output sas_pkg::sas_mux_s              muxSel,
   output logic                           sampleOn,
   output logic [sas_pkg::RES_BITS-1:0]   trialBits,
   input  wire logic                      compAbove,
   // Status
   output logic                           convDone,
   output logic                           powerDown,
   output logic [sas_pkg::RES_BITS-1:0]   result
);
   import sas_pkg::*;

   function automatic sas_mux_s decodeAddr(input logic [3:0] a);
      sas_mux_s m;
      m.ext   = (a <= ADDR_LAST_EXT);
      m.chan  = (a <= ADDR_LAST_EXT) ? a : 4'h0;
      m.pwrDn = (a == ADDR_PWRDN);
      case (a)
         ADDR_MID:  m.src = SAS_SRC_MID;
         ADDR_LOW:  m.src = SAS_SRC_LOW;
         ADDR_HIGH: m.src = SAS_SRC_HIGH;
         default:   m.src = SAS_SRC_EXT;
      endcase
      return m;
   endfunction : decodeAddr

   function automatic logic [4:0] lastEdge(input logic [1:0] len);
      case (len)
         LEN_8:   lastEdge = EDGES_8;
         LEN_16:  lastEdge = EDGES_16;
         default: lastEdge = EDGES_12;
      endcase
   endfunction : lastEdge

   ////////////////////////////////////////////////////////////////////////////
   // Select debounce in the system domain
   logic       selS1_q, selS2_q;
   logic       selDb_q, selDb_d;
   logic [7:0] dbCnt_q, dbCnt_d;
   logic       swRst_q, swRst_d;

   always_comb begin
      selDb_d = selDb_q;
      dbCnt_d = 8'h00;
      swRst_d = 1'b0;
      if (selS2_q != selDb_q) begin
         dbCnt_d = dbCnt_q + 8'h01;
         if (dbCnt_q == 8'(DEBOUNCE_CYC - 1)) begin
            selDb_d = selS2_q;
            dbCnt_d = 8'h00;
            swRst_d = !selS2_q;
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         selS1_q <= 1'b1;
         selS2_q <= 1'b1;
         selDb_q <= 1'b1;
         dbCnt_q <= 8'h00;
         swRst_q <= 1'b0;
      end else begin
         selS1_q <= selectN;
         selS2_q <= selS1_q;
         selDb_q <= selDb_d;
         dbCnt_q <= dbCnt_d;
         swRst_q <= swRst_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Link domain: commands in, result out on falling shift clock
   logic        inhS1_q, inhS2_q;
   logic        rstTgS1_q, rstTgS2_q, rstTgS3_q, rstTg_q;
   logic [4:0]  edgeCnt_q, edgeCnt_d;
   logic [7:0]  cmd_q, cmd_d;
   logic [15:0] outWord;
   logic        cycTg_q, cycTg_d;
   logic [7:0]  cycCmd_q, cycCmd_d;
   logic        pdTg_q, pdTg_d;
   logic [RES_BITS-1:0] outBuf;

   // Debounced high stalls the link; a new reset reloads it
   always_ff @(negedge ioClk or negedge rst_n) begin
      if (!rst_n) begin
         inhS1_q   <= 1'b1;
         inhS2_q   <= 1'b1;
         rstTgS1_q <= 1'b0;
         rstTgS2_q <= 1'b0;
         rstTgS3_q <= 1'b0;
      end else begin
         inhS1_q   <= selDb_q;
         inhS2_q   <= inhS1_q;
         rstTgS1_q <= rstTg_q;
         rstTgS2_q <= rstTgS1_q;
         rstTgS3_q <= rstTgS2_q;
      end
   end

   always_comb begin
      edgeCnt_d = edgeCnt_q;
      cmd_d     = cmd_q;
      cycTg_d   = cycTg_q;
      cycCmd_d  = cycCmd_q;
      pdTg_d    = pdTg_q;
      if (rstTgS3_q != rstTgS2_q) begin
         edgeCnt_d = 5'h00;
      end else if (!inhS2_q) begin
         // Command freezes after eight bits so length and address survive long cycles
         if (edgeCnt_q < EDGES_8)
            cmd_d = {cmd_q[6:0], dataIn};
         edgeCnt_d = edgeCnt_q + 5'h01;
         if (edgeCnt_q + 5'h01 == EDGE_ADDR && decodeAddr(cmd_d[3:0]).pwrDn)
            pdTg_d = !pdTg_q;
         if (edgeCnt_q + 5'h01 == lastEdge(cmd_d[3:2]) && edgeCnt_q >= EDGE_ADDR) begin
            cycTg_d   = !cycTg_q;
            cycCmd_d  = cmd_d;
            edgeCnt_d = 5'h00;
         end
      end
   end

   always_ff @(negedge ioClk or negedge rst_n) begin
      if (!rst_n) begin
         edgeCnt_q <= 5'h00;
         cmd_q     <= 8'h00;
         cycTg_q   <= 1'b0;
         cycCmd_q  <= 8'h00;
         pdTg_q    <= 1'b0;
      end else begin
         edgeCnt_q <= edgeCnt_d;
         cmd_q     <= cmd_d;
         cycTg_q   <= cycTg_d;
         cycCmd_q  <= cycCmd_d;
         pdTg_q    <= pdTg_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Conversion engine in the system domain
   sas_state_e          state_q, state_d;
   logic [2:0]          cycS_q, pdS_q;
   logic [3:0]          step_q, step_d;
   logic [RES_BITS-1:0] trial_q, trial_d, res_q, res_d;
   logic                pd_q, pd_d, eoc_q, eoc_d, smp_q, smp_d, oe_q, oe_d;
   sas_mux_s            mux_q, mux_d;
   logic                rstReq_q, rstReq_d;
   logic                cycEvt, pdEvt;
   logic [3:0]          cycAddr;

   assign cycEvt  = cycS_q[2] ^ cycS_q[1];
   assign pdEvt   = pdS_q[2] ^ pdS_q[1];
   assign cycAddr = cycCmd_q[7:4];
   assign outBuf  = res_q;

   always_comb begin
      state_d  = state_q;
      step_d   = step_q;
      trial_d  = trial_q;
      res_d    = res_q;
      pd_d     = pd_q;
      eoc_d    = eoc_q;
      smp_d    = smp_q;
      mux_d    = mux_q;
      rstReq_d = rstReq_q ^ swRst_q;
      oe_d     = !selS2_q;
      if (pdEvt)
         pd_d = 1'b1;
      case (state_q)
         SAS_IDLE: begin
            if (pd_q)
               smp_d = 1'b0;
            else
               smp_d = 1'b1;
            if (cycEvt) begin
               mux_d = decodeAddr(cycAddr);
               if (decodeAddr(cycAddr).pwrDn) begin
                  pd_d = 1'b1;
               end else begin
                  pd_d    = 1'b0;
                  smp_d   = 1'b0;
                  eoc_d   = 1'b0;
                  step_d  = 4'(RES_BITS - 1);
                  trial_d = 12'h800;
                  state_d = SAS_CONV;
               end
            end
         end
         SAS_CONV: begin
            if (compAbove)
               trial_d[step_q] = 1'b0;
            if (step_q == 4'h0) begin
               state_d = SAS_DONE;
            end else begin
               step_d = step_q - 4'h1;
               trial_d[step_q - 4'h1] = 1'b1;
            end
         end
         SAS_DONE: begin
            res_d   = trial_q;
            eoc_d   = 1'b1;
            state_d = SAS_IDLE;
         end
         default: state_d = SAS_IDLE;
      endcase
      if (swRst_q) begin
         state_d = SAS_IDLE;
         eoc_d   = 1'b1;
         res_d   = res_q;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_q  <= SAS_IDLE;
         cycS_q   <= 3'h0;
         pdS_q    <= 3'h0;
         step_q   <= 4'h0;
         trial_q  <= 12'h000;
         res_q    <= RESULT_RST;
         pd_q     <= 1'b1;
         eoc_q    <= 1'b1;
         smp_q    <= 1'b0;
         oe_q     <= 1'b0;
         mux_q    <= '0;
         rstReq_q <= 1'b0;
      end else begin
         state_q  <= state_d;
         cycS_q   <= {cycS_q[1:0], cycTg_q};
         pdS_q    <= {pdS_q[1:0], pdTg_q};
         step_q   <= step_d;
         trial_q  <= trial_d;
         res_q    <= res_d;
         pd_q     <= pd_d;
         eoc_q    <= eoc_d;
         smp_q    <= smp_d;
         oe_q     <= oe_d;
         mux_q    <= mux_d;
         rstReq_q <= rstReq_d;
      end
   end
   assign rstTg_q = rstReq_q;

   // Data bit driven at the link edge; enable tracks select
   // Held result picked by bit count, so a new result shows without a reload
   assign outWord   = {outBuf, 4'h0};
   assign dataOut   = eoc_q & outWord[4'hF - edgeCnt_q[3:0]];
   assign dataOutEn = oe_q;
   assign muxSel    = mux_q;
   assign sampleOn  = smp_q;
   assign trialBits = trial_q;
   assign convDone  = eoc_q;
   assign powerDown = pd_q;
   assign result    = res_q;

   ////////////////////////////////////////////////////////////////////////////
   property p_pdReset;
      @(posedge clk) disable iff (!rst_n)
      $rose(rst_n) |-> pd_q;
   endproperty
   a_pdReset: assert property (p_pdReset) else $error("not in power-down");

   property p_oeOff;
      @(posedge clk) disable iff (!rst_n)
      selS2_q |=> !dataOutEn;
   endproperty
   a_oeOff: assert property (p_oeOff) else $error("output not released");

   property p_conv12;
      @(posedge clk) disable iff (!rst_n)
      (state_q == SAS_IDLE && state_d == SAS_CONV && !swRst_q)
         |=> (state_q == SAS_CONV)[*8] ##5 (state_q == SAS_DONE || swRst_q);
   endproperty
   a_conv12: assert property (p_conv12) else $error("bad step count");

   property p_eoc;
      @(posedge clk) disable iff (!rst_n)
      (state_q == SAS_DONE) |=> convDone && result == $past(trial_q);
   endproperty
   a_eoc: assert property (p_eoc) else $error("result not latched");

   property p_pdNoConv;
      @(posedge clk) disable iff (!rst_n)
      (pd_q && state_q == SAS_IDLE && !cycEvt) |=> state_q == SAS_IDLE;
   endproperty
   a_pdNoConv: assert property (p_pdNoConv) else $error("conversion in power-down");

   property p_wake;
      @(posedge clk) disable iff (!rst_n)
      (cycEvt && state_q == SAS_IDLE && !swRst_q && cycAddr != ADDR_PWRDN)
         |=> !pd_q && !convDone;
   endproperty
   a_wake: assert property (p_wake) else $error("no wake conversion");

   property p_debounce;
      @(posedge clk) disable iff (!rst_n)
      swRst_q |-> !selDb_q && $past(selDb_q, 2);
   endproperty
   a_debounce: assert property (p_debounce) else $error("reset before debounce");

   property p_abort;
      @(posedge clk) disable iff (!rst_n)
      swRst_q |=> state_q == SAS_IDLE && result == $past(result);
   endproperty
   a_abort: assert property (p_abort) else $error("abort lost result");

endmodule : sas_ctrl
`default_nettype wire

/* hdl/sas_pkg.sv */
package sas_pkg;

   localparam int          RES_BITS       = 12;
   localparam logic [3:0]  ADDR_PWRDN     = 4'hE;
   localparam logic [3:0]  ADDR_LAST_EXT  = 4'hA;
   localparam logic [3:0]  ADDR_MID       = 4'hB;
   localparam logic [3:0]  ADDR_LOW       = 4'hC;
   localparam logic [3:0]  ADDR_HIGH      = 4'hD;
   localparam logic [1:0]  LEN_8          = 2'h1;
   localparam logic [1:0]  LEN_16         = 2'h3;
   localparam logic [4:0]  EDGES_8        = 5'h08;
   localparam logic [4:0]  EDGES_12       = 5'h0C;
   localparam logic [4:0]  EDGES_16       = 5'h10;
   localparam logic [4:0]  EDGE_ADDR      = 5'h04;
   localparam int          CLK_MHZ        = 100;
   localparam int          DEBOUNCE_NS    = 100;
   localparam int          DEBOUNCE_CYC   = (DEBOUNCE_NS * CLK_MHZ + 999) / 1000;
   localparam logic [11:0] RESULT_RST     = 12'h000;

   // Input selection decoded from the address
   typedef enum logic [1:0] {
      SAS_SRC_EXT  = 2'b00,
      SAS_SRC_MID  = 2'b01,
      SAS_SRC_LOW  = 2'b10,
      SAS_SRC_HIGH = 2'b11
   } sas_src_e;

   typedef struct packed {
      logic       ext;
      sas_src_e   src;
      logic [3:0] chan;
      logic       pwrDn;
   } sas_mux_s;

   typedef enum logic [1:0] {
      SAS_IDLE   = 2'b00,
      SAS_SAMPLE = 2'b01,
      SAS_CONV   = 2'b10,
      SAS_DONE   = 2'b11
   } sas_state_e;

endpackage : sas_pkg

/* test/sas_host.sv */
`timescale 1ns/10ps
`default_nettype none
module sas_host (
   // System
   input  wire logic                        clk,
   // Serial link
   output logic                             ioClk,
   output logic                             selectN,
   output logic                             dataIn,
   input  wire logic                        dataOut,
   input  wire logic                        dataOutEn,
   // Analog front end
   input  wire sas_pkg::sas_mux_s           muxSel,
   input  wire logic [sas_pkg::RES_BITS-1:0] trialBits,
   output logic                             compAbove
);
   import sas_pkg::*;
   logic        junk = 1'b0;
   logic [12:0] vin;
   logic        lineV;
   initial begin
      ioClk = 1'b0;
      selectN = 1'b1;
      dataIn = 1'b0;
   end
   ////////////////////////////////////////////////////////////////////////////////
   // Released line toggles so a stale bit cannot pass
   always @(posedge clk) junk <= ~junk;
   assign lineV = dataOutEn ? dataOut : junk;
   // Channel 10 sits above full scale to force saturation
   always_comb begin
      case (muxSel.src)
         SAS_SRC_MID:  vin = 13'h0800;
         SAS_SRC_LOW:  vin = 13'h0000;
         SAS_SRC_HIGH: vin = 13'h0FFF;
         default:      vin = (muxSel.chan == 4'hA) ? 13'h1400 : 13'(muxSel.chan) * 13'h0190;
      endcase
   end
   assign compAbove = {1'b0, trialBits} > vin;
   ////////////////////////////////////////////////////////////////////////////////
   task automatic sel(input logic v);
      @(posedge clk);
      selectN <= v;
      repeat (DEBOUNCE_CYC + 4) @(posedge clk);
      // Link resync needs three edges before the real cycle
      if (!v) begin
         repeat (3) begin
            #24 ioClk = 1'b1;
            #24 ioClk = 1'b0;
         end
      end
      #144;
   endtask : sel
   // Shift clock runs n pulses here, plus the three resync pulses in sel
   task automatic frame(input logic [7:0] cmd, input int n, output logic [15:0] got);
      got = 16'h0000;
      for (int i = 0; i < n; i++) begin
         #24 ioClk = 1'b1;
         // Bit changes at the rise, away from the sampling fall
         dataIn = (i < 8) ? cmd[7-i] : 1'b0;
         got[15-i] = lineV;
         #24 ioClk = 1'b0;
      end
   endtask : frame
endmodule : sas_host
`default_nettype wire

/* test/tb.sv */
`timescale 1ns/10ps
`default_nettype none
module tb;
   import sas_pkg::*;
   logic                clk = 1'b0;
   logic                rst_n = 1'b0;
   logic                ioClk, selectN, dataIn, dataOut, dataOutEn, compAbove;
   logic                sampleOn, convDone, powerDown;
   logic [RES_BITS-1:0] trialBits, result;
   sas_mux_s            muxSel;
   int                  fails = 0;
   int                  n_checks = 0;
   logic [15:0]         got;
   logic [11:0]         prev = 12'h000;
   logic [3:0]          codes [17] = '{4'hE, 4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7,
                                       4'h8, 4'h9, 4'hA, 4'hB, 4'hC, 4'hD, 4'hF, 4'hE};
   logic [1:0]          lens [3] = '{2'h0, 2'h1, 2'h3};
   int                  nb [3] = '{12, 8, 16};
   always #5 clk = ~clk;
   sas_ctrl dut (.clk(clk), .rst_n(rst_n), .ioClk(ioClk), .selectN(selectN), .dataIn(dataIn),
      .dataOut(dataOut), .dataOutEn(dataOutEn), .muxSel(muxSel), .sampleOn(sampleOn),
      .trialBits(trialBits), .compAbove(compAbove), .convDone(convDone),
      .powerDown(powerDown), .result(result));
   sas_host host (.clk(clk), .ioClk(ioClk), .selectN(selectN), .dataIn(dataIn),
      .dataOut(dataOut), .dataOutEn(dataOutEn), .muxSel(muxSel), .trialBits(trialBits),
      .compAbove(compAbove));
   ////////////////////////////////////////////////////////////////////////////////
   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      n_checks++;
      if (seen !== exp) begin
         fails++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic close_out;
      $display("Checks %0d mismatches %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : close_out
   // Saturated and self-test codes give fixed results
   function automatic logic [11:0] expect_res(input logic [3:0] a);
      case (a)
         ADDR_MID:  return 12'h800;
         ADDR_LOW:  return 12'h000;
         ADDR_HIGH: return 12'hFFF;
         4'hA:      return 12'hFFF;
         default:   return 12'(a * 12'h190);
      endcase
   endfunction : expect_res
   task automatic run(input logic [7:0] cmd, input int n);
      int lows;
      lows = 0;
      host.frame(cmd, n, got);
      if (n == 8) check("dataOut8", {8'h00, got[15:8]}, {8'h00, prev[11:4]});
      else check("dataOut", {4'h0, got[15:4]}, {4'h0, prev});
      for (int i = 0; i < 60; i++) begin
         @(posedge clk);
         if (convDone !== 1'b1) lows++;
         else if (lows > 0) break;
      end
      if (convDone !== 1'b1) begin
         fails++;
         close_out();
      end
      if (cmd[7:4] == ADDR_PWRDN) begin
         check("noConv", 16'(lows), 16'h0000);
         check("powerDown", {15'h0, powerDown}, 16'h0001);
         check("sampleOn", {15'h0, sampleOn}, 16'h0000);
      end else begin
         check("convLen", 16'(lows), 16'd13);
         check("powerDown", {15'h0, powerDown}, 16'h0000);
         if (cmd[7:4] <= ADDR_LAST_EXT) begin
            check("muxExt", {11'h0, muxSel.ext, muxSel.chan}, {11'h1, cmd[7:4]});
         end else if (cmd[7:4] != 4'hF) begin
            check("muxSrc", {14'h0, muxSel.src}, 16'(cmd[7:4] - 4'hA));
         end
         if (cmd[7:4] != 4'hF) check("result", 16'(result), 16'(expect_res(cmd[7:4])));
         prev = result;
      end
   endtask : run
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      #900000;
      fails++;
      close_out();
   end
   initial begin
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      #1;
      check("rstPd", {15'h0, powerDown}, 16'h0001);
      check("rstEoc", {15'h0, convDone}, 16'h0001);
      check("rstRes", 16'(result), 16'h0000);
      host.sel(1'b0);
      check("enLow", {15'h0, dataOutEn}, 16'h0001);
      // Saturation on channel 10 and the lower and upper references
      foreach (codes[k]) run({codes[k], lens[k % 3], 2'h0}, nb[k % 3]);
      host.sel(1'b1);
      check("enHigh", {15'h0, dataOutEn}, 16'h0000);
      host.frame(8'h30, 12, got);
      repeat (30) @(posedge clk);
      check("inhEoc", {15'h0, convDone}, 16'h0001);
      check("inhPd", {15'h0, powerDown}, 16'h0001);
      host.sel(1'b0);
      // Abort in mid-transfer keeps the old result
      host.frame(8'h30, 6, got);
      host.sel(1'b1);
      host.sel(1'b0);
      run(8'h10, 12);
      close_out();
   end
endmodule : tb
`default_nettype wire
